// file: sdram_timing_pkg.sv
// Purpose: shared constants and carriers for the SDRAM command sequencer
// Assumes: 100 MHz system clock, single clock domain
// Notes: counts are in clock cycles unless named in another unit
package sdram_timing_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int INIT_PAUSE_US = 100;
   localparam int INIT_PAUSE_CYC = (INIT_PAUSE_US * 1000 + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int INIT_REFRESHES = 2;
   localparam int DATA_W = 32;
   localparam int MASK_W = 4;
   localparam int ADDR_W = 13;
   localparam int BANK_W = 2;
   localparam int FIFO_DEPTH = 8;
   // command encodings as {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACTIVE = 4'h3;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_BURST_STOP = 4'h6;
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
   localparam int AUTO_PRE_BIT = 10;
   // user request opcodes
   localparam logic [2:0] OP_ACTIVE = 3'h0;
   localparam logic [2:0] OP_READ = 3'h1;
   localparam logic [2:0] OP_WRITE = 3'h2;
   localparam logic [2:0] OP_PRECHARGE = 3'h3;
   localparam logic [2:0] OP_REFRESH = 3'h4;
   localparam logic [2:0] OP_MODE_LOAD = 3'h5;
   localparam logic [2:0] OP_BURST_STOP = 3'h6;
   localparam logic [2:0] OP_SUSPEND = 3'h7;

   typedef struct packed {
      logic [2:0] op;
      logic auto_pre;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [MASK_W-1:0] mask;
   } req_s;
   localparam int REQ_W = $bits(req_s);

   typedef enum logic [2:0] {
      ST_PAUSE = 3'b000,
      ST_INIT_REF = 3'b001,
      ST_READY = 3'b010,
      ST_SUSPEND = 3'b011,
      ST_WAKE = 3'b100
   } seq_e;
endpackage

// file: req_fifo.sv
// Purpose: request buffer between user port and SDRAM sequencer
// Assumes: single clock, synchronous reset copy
// Notes: first-word-fall-through, honest full and empty
`timescale 1ns/1ps
module req_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // storage words
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt; // occupancy
   logic push, pop;
   logic full_r, full_nxt; // registered full, so the ready pin is a flop

   assign in_ready = !full_r;
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointer and count next values
   always_comb begin
      wp_nxt = push ? AW'((wp_r + 1'b1) % DEPTH) : wp_r;
      rp_nxt = pop ? AW'((rp_r + 1'b1) % DEPTH) : rp_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      full_nxt = (cnt_nxt == (AW+1)'(DEPTH));
   end

   // register pointers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         full_r <= 1'b0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         full_r <= full_nxt;
      end
   end

   // storage has no reset, so it stays out of the reset branch
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end
endmodule

// file: sdram_cmd_seq.sv
// Purpose: host-side sequencer that spaces SDRAM commands by cycle rules
// Assumes: 100 MHz CLK; user supplies commands in legal logical order
// Notes: no bank/row tracking beyond the per-rule spacing counters
`timescale 1ns/1ps
import sdram_timing_pkg::*;

module sdram_cmd_seq import sdram_timing_pkg::*; #(
   parameter int INIT_CYC = INIT_PAUSE_CYC,
   parameter int COL_GAP = 1, // col_to_col_gap
   parameter int SUSP_EXIT = 1, // suspend_exit_lat
   parameter int WD_TO_ACT = 5, // wdata_to_activate, 4 on slower grades
   parameter int WD_TO_PRE = 2, // wdata_to_precharge
   parameter int WD_TO_STOP = 1, // wdata_to_burst_stop
   parameter int WD_TO_COL = 1, // wdata_to_new_col
   parameter int MODE_TO_CMD = 2, // modeload_to_cmd
   parameter int FIFO_D = FIFO_DEPTH
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [REQ_W-1:0] REQ_DATA,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire logic REFRESH_LOST,
   input wire logic RESUME,
   output logic CKE,
   output logic CS_N,
   output logic RAS_N,
   output logic CAS_N,
   output logic WE_N,
   output logic [BANK_W-1:0] BA,
   output logic [ADDR_W-1:0] A,
   output logic [MASK_W-1:0] DQM,
   output logic [DATA_W-1:0] DQ_O,
   output logic DQ_OE,
   output logic INIT_DONE,
   output logic REQ_READY_R
);
   localparam int CW = 16; // width of spacing counters
   localparam int PW = $clog2(INIT_CYC + 1) + 1;

   ////////////////////////////////////////////////////////////////////////
   // reset release through two flops
   logic rs1_r, rs2_r, rst_n;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rs1_r <= 1'b0;
         rs2_r <= 1'b0;
      end else begin
         rs1_r <= 1'b1;
         rs2_r <= rs1_r;
      end
   end
   assign rst_n = rs2_r;

   ////////////////////////////////////////////////////////////////////////
   // request buffer; pop only when a command issues or suspend is entered
   logic [REQ_W-1:0] f_data;
   logic f_valid, f_ready, in_rdy;
   req_s rq;
   req_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_D)) u_fifo (
      .clk(CLK), .rst_n(rst_n),
      .in_data(REQ_DATA), .in_valid(REQ_VALID), .in_ready(in_rdy),
      .out_data(f_data), .out_valid(f_valid), .out_ready(f_ready)
   );
   assign REQ_READY = in_rdy;
   assign rq = req_s'(f_data);

   // counter loaded with n-1 means n clocks spacing
   function automatic logic [CW-1:0] gap(input int n);
      gap = (n > 0) ? CW'(n - 1) : '0;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // sequencer state
   seq_e st_r, st_nxt;
   logic [PW-1:0] pause_r, pause_nxt;
   logic [1:0] nref_r, nref_nxt;
   logic [CW-1:0] col_r, col_nxt, act_r, act_nxt, pre_r, pre_nxt;
   logic [CW-1:0] stop_r, stop_nxt, mode_r, mode_nxt;
   logic [3:0] cmd_nxt;
   logic [BANK_W-1:0] ba_nxt;
   logic [ADDR_W-1:0] a_nxt;
   logic [MASK_W-1:0] dqm_nxt;
   logic [DATA_W-1:0] dq_nxt;
   logic oe_nxt, cke_nxt, done_nxt, pop;
   logic [3:0] cmd_r;
   logic [BANK_W-1:0] ba_r;
   logic [ADDR_W-1:0] a_r;
   logic [MASK_W-1:0] dqm_r;
   logic [DATA_W-1:0] dq_r;
   logic oe_r, cke_r, done_r, rdy_r;

   // is the head request allowed to issue this cycle
   function automatic logic may_issue(input logic [2:0] op,
         input logic [CW-1:0] col, act, pre, stp, mde);
      case (op)
         OP_READ, OP_WRITE: may_issue = (col == '0);
         OP_ACTIVE: may_issue = (act == '0) && (mde == '0);
         OP_REFRESH: may_issue = (mde == '0);
         OP_PRECHARGE: may_issue = (pre == '0);
         OP_BURST_STOP: may_issue = (stp == '0);
         default: may_issue = 1'b1;
      endcase
   endfunction

   // next-state and pin values
   always_comb begin
      st_nxt = st_r;
      pause_nxt = pause_r;
      nref_nxt = nref_r;
      col_nxt = (col_r != '0) ? col_r - 1'b1 : col_r;
      act_nxt = (act_r != '0) ? act_r - 1'b1 : act_r;
      pre_nxt = (pre_r != '0) ? pre_r - 1'b1 : pre_r;
      stop_nxt = (stop_r != '0) ? stop_r - 1'b1 : stop_r;
      mode_nxt = (mode_r != '0) ? mode_r - 1'b1 : mode_r;
      cmd_nxt = CMD_NOP;
      ba_nxt = ba_r;
      a_nxt = a_r;
      dqm_nxt = dqm_r;
      dq_nxt = dq_r;
      oe_nxt = 1'b0;
      cke_nxt = 1'b1; // clock stays running; CKE alone stops traffic
      done_nxt = done_r;
      pop = 1'b0;
      case (st_r)
         ST_PAUSE: begin
            done_nxt = 1'b0;
            if (pause_r != '0) begin
               pause_nxt = pause_r - 1'b1; // power-up pause
            end else begin
               st_nxt = ST_INIT_REF;
               nref_nxt = 2'(INIT_REFRESHES);
            end
         end
         ST_INIT_REF: begin
            if (nref_r == '0) begin
               st_nxt = ST_READY;
               done_nxt = 1'b1;
            end else if ((act_r == '0) && (mode_r == '0)) begin
               cmd_nxt = CMD_REFRESH; // wake-up refreshes
               nref_nxt = nref_r - 1'b1;
               act_nxt = gap(WD_TO_ACT);
            end
         end
         ST_READY: begin
            if (REFRESH_LOST) begin
               st_nxt = ST_INIT_REF; // redo wake-up sequence
               nref_nxt = 2'(INIT_REFRESHES);
               done_nxt = 1'b0;
            end else if (f_valid &&
                  may_issue(rq.op, col_r, act_r, pre_r, stop_r, mode_r)) begin
               pop = 1'b1;
               ba_nxt = rq.bank;
               a_nxt = rq.addr;
               dqm_nxt = rq.mask;
               case (rq.op)
                  OP_ACTIVE: cmd_nxt = CMD_ACTIVE;
                  OP_READ: begin
                     cmd_nxt = CMD_READ;
                     a_nxt[AUTO_PRE_BIT] = rq.auto_pre;
                     col_nxt = gap(COL_GAP);
                  end
                  OP_WRITE: begin
                     cmd_nxt = CMD_WRITE;
                     a_nxt[AUTO_PRE_BIT] = rq.auto_pre;
                     dq_nxt = rq.wdata; // data with command
                     oe_nxt = 1'b1; // masked lanes dropped by memory
                     col_nxt = gap(WD_TO_COL);
                     pre_nxt = gap(WD_TO_PRE + 1);
                     stop_nxt = gap(WD_TO_STOP);
                     if (rq.auto_pre) begin
                        act_nxt = gap(WD_TO_ACT + 1);
                     end
                  end
                  OP_PRECHARGE: cmd_nxt = CMD_PRECHARGE;
                  OP_REFRESH: cmd_nxt = CMD_REFRESH;
                  OP_BURST_STOP: cmd_nxt = CMD_BURST_STOP;
                  OP_MODE_LOAD: begin
                     cmd_nxt = CMD_MODE_LOAD;
                     mode_nxt = gap(MODE_TO_CMD + 1);
                  end
                  default: begin
                     cke_nxt = 1'b0; // memory stops next clock
                     st_nxt = ST_SUSPEND;
                  end
               endcase
            end
         end
         ST_SUSPEND: begin
            cke_nxt = 1'b0;
            if (RESUME) begin
               cke_nxt = 1'b1;
               st_nxt = ST_WAKE;
               pause_nxt = PW'(SUSP_EXIT);
            end
         end
         ST_WAKE: begin
            // hold NOPs for the exit setup clock
            if (pause_r > PW'(1)) begin
               pause_nxt = pause_r - 1'b1;
            end else begin
               pause_nxt = '0;
               st_nxt = ST_READY;
            end
         end
         default: st_nxt = ST_PAUSE;
      endcase
   end
   assign f_ready = pop;

   // register everything; every pin comes from a flop
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= ST_PAUSE;
         pause_r <= PW'(INIT_CYC);
         nref_r <= '0;
         col_r <= '0;
         act_r <= '0;
         pre_r <= '0;
         stop_r <= '0;
         mode_r <= '0;
         cmd_r <= CMD_NOP;
         ba_r <= '0;
         a_r <= '0;
         dqm_r <= '1;
         dq_r <= '0;
         oe_r <= 1'b0;
         cke_r <= 1'b1;
         done_r <= 1'b0;
         rdy_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         pause_r <= pause_nxt;
         nref_r <= nref_nxt;
         col_r <= col_nxt;
         act_r <= act_nxt;
         pre_r <= pre_nxt;
         stop_r <= stop_nxt;
         mode_r <= mode_nxt;
         cmd_r <= cmd_nxt;
         ba_r <= ba_nxt;
         a_r <= a_nxt;
         dqm_r <= dqm_nxt;
         dq_r <= dq_nxt;
         oe_r <= oe_nxt;
         cke_r <= cke_nxt;
         done_r <= done_nxt;
         rdy_r <= in_rdy;
      end
   end

   assign {CS_N, RAS_N, CAS_N, WE_N} = cmd_r;
   assign BA = ba_r;
   assign A = a_r;
   assign DQM = dqm_r;
   assign DQ_O = dq_r;
   assign DQ_OE = oe_r;
   assign CKE = cke_r;
   assign INIT_DONE = done_r;
   assign REQ_READY_R = rdy_r;
endmodule

// file: sdram_dev_model.sv
// Purpose: behavioural memory that answers the command sequencer
// Assumes: commands sampled on the rising clock edge
// Notes: 16 words only; column address bits 3:0 pick the word
`timescale 1ns/1ps
module sdram_dev_model import sdram_timing_pkg::*; (
   input wire logic clk,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [BANK_W-1:0] ba,
   input wire logic [ADDR_W-1:0] a,
   input wire logic [MASK_W-1:0] dqm,
   input wire logic [DATA_W-1:0] dq
);
   logic cke_q; // clock enable seen one edge back
   logic [3:0] cmd; // decoded command
   logic [3:0] c_prev, c_now; // last two commands
   int cyc, t_prev, t_now; // their edge numbers
   int n_cmd [16]; // count of each command
   logic [DATA_W-1:0] mem [16]; // stored words
   localparam int READ_LATENCY_SETTING = 2; // latency this model runs at
   localparam int BURST_LEN = 4; // read burst length of this model
   logic [BANK_W-1:0] b_now; // bank of the last command
   int rd_left; // clocks until the read burst has ended
   logic [MASK_W-1:0] dqm_q1, dqm_q2; // mask one and two edges back
   logic [MASK_W-1:0] lanes_on; // byte lanes the memory would drive
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   // a read mask floats its lanes two edges after it is sampled
   assign lanes_on = (rd_left > 0 && rd_left <= BURST_LEN) ? ~dqm_q2 : '0;
   //////////////////////////////////////////////
   initial begin
      cke_q = 1'b1;
      cyc = 0;
      rd_left = 0;
      dqm_q1 = '1;
      dqm_q2 = '1;
      foreach (mem[i]) mem[i] = '0;
   end
   // suspend takes hold one edge after clock enable low
   always @(posedge clk) begin
      cyc <= cyc + 1;
      cke_q <= cke;
      dqm_q1 <= dqm;
      dqm_q2 <= dqm_q1;
      // a precharge cuts a read burst short after the read latency
      if (cke_q && cmd == CMD_READ) begin
         rd_left <= READ_LATENCY_SETTING + BURST_LEN;
      end else if (cke_q && cmd == CMD_PRECHARGE &&
            rd_left > READ_LATENCY_SETTING) begin
         rd_left <= READ_LATENCY_SETTING;
      end else if (rd_left > 0) begin
         rd_left <= rd_left - 1;
      end
      if (cke_q && cmd != CMD_NOP) begin
         n_cmd[cmd] <= n_cmd[cmd] + 1;
         b_now <= ba;
         c_prev <= c_now;
         c_now <= cmd;
         t_prev <= t_now;
         t_now <= cyc;
         // data rides with the write; masked lanes keep old bytes
         if (cmd == CMD_WRITE) begin
            for (int b = 0; b < MASK_W; b++) begin
               if (!dqm[b]) mem[a[3:0]][8*b +: 8] <= dq[8*b +: 8];
            end
         end
      end
   end
endmodule

// file: sdram_cmd_seq_properties.sv
// Purpose: timing checks on the sequencer command pins
// Assumes: one clock, RST_B active low
// Notes: command is {CS_N, RAS_N, CAS_N, WE_N}
`timescale 1ns/1ps
module sdram_cmd_seq_checker import sdram_timing_pkg::*; #(
   parameter int INIT_CYC = INIT_PAUSE_CYC
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic RESUME,
   input wire logic CKE,
   input wire logic CS_N,
   input wire logic RAS_N,
   input wire logic CAS_N,
   input wire logic WE_N,
   input wire logic [ADDR_W-1:0] A,
   input wire logic DQ_OE,
   input wire logic INIT_DONE
);
   logic [3:0] cmd; // decoded command
   logic [15:0] cyc_r; // cycles since release, saturating
   logic [1:0] refs_r; // refreshes while not ready
   assign cmd = {CS_N, RAS_N, CAS_N, WE_N};
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   //////////////////////////////////////////////
   // the cycle counter saturates so a long run never wraps; refs_r clears when init is done
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         cyc_r <= '0;
         refs_r <= '0;
      end else begin
         if (cyc_r != 16'hFFFF) cyc_r <= cyc_r + 16'h1;
         if (INIT_DONE) refs_r <= '0;
         else if (cmd == CMD_REFRESH) refs_r <= refs_r + 2'h1;
      end
   end
   AST_PAUSE: assert property (
      (cmd == CMD_REFRESH && !INIT_DONE) |-> cyc_r >= INIT_CYC)
      else $error("refresh before pause ended");
   AST_EARLY: assert property (
      !INIT_DONE |-> (cmd == CMD_NOP || cmd == CMD_REFRESH))
      else $error("command before init done");
   AST_TWO_REF: assert property (
      $rose(INIT_DONE) |-> (refs_r == 2'h2 ||
      (refs_r == 2'h1 && cmd == CMD_REFRESH)))
      else $error("ready without two refreshes");
   AST_REF_GAP: assert property (
      (cmd == CMD_REFRESH && !INIT_DONE) |=> (cmd != CMD_REFRESH) [*4])
      else $error("wake refreshes too close");
   AST_WR_PRE: assert property (
      cmd == CMD_WRITE |=> (cmd != CMD_PRECHARGE) [*2])
      else $error("precharge too soon after write");
   AST_WR_ACT: assert property (
      (cmd == CMD_WRITE && A[AUTO_PRE_BIT]) |=> (cmd != CMD_ACTIVE) [*5])
      else $error("activate too soon after auto precharge write");
   AST_MODE: assert property (
      cmd == CMD_MODE_LOAD |=>
      (cmd != CMD_ACTIVE && cmd != CMD_REFRESH) [*2])
      else $error("activate or refresh too soon after mode load");
   AST_DATA: assert property (
      DQ_OE == (cmd == CMD_WRITE))
      else $error("write data not with write command");
   AST_SUSP: assert property (
      (!CKE || $rose(CKE)) |-> cmd == CMD_NOP)
      else $error("command while suspended");
   AST_WAKE: assert property (
      (!CKE && RESUME) |=> CKE)
      else $error("clock enable late after resume");
endmodule

bind sdram_cmd_seq sdram_cmd_seq_checker #(.INIT_CYC(INIT_CYC)) u_chk (
   .CLK(CLK), .RST_B(RST_B), .RESUME(RESUME), .CKE(CKE), .CS_N(CS_N),
   .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .A(A), .DQ_OE(DQ_OE),
   .INIT_DONE(INIT_DONE));

// file: sdram_cmd_seq_tb.sv
// Purpose: self-checking bench for the command sequencer
// Assumes: pause shortened to 20 cycles
// Notes: the memory model counts and times every command except NOP
`timescale 1ns/1ps
module sdram_cmd_seq_tb import sdram_timing_pkg::*;;
   logic clk, rst_b, vld, lost, resume, rdy, rdy_r, cke, done;
   logic cs_n, ras_n, cas_n, we_n, oe;
   logic [BANK_W-1:0] ba;
   logic [ADDR_W-1:0] a;
   logic [MASK_W-1:0] dqm;
   logic [DATA_W-1:0] dq;
   req_s rq; // request offered to the queue
   int errors, checked;
   sdram_cmd_seq #(.INIT_CYC(20)) u_dut (.CLK(clk), .RST_B(rst_b),
      .REQ_DATA(rq), .REQ_VALID(vld), .REQ_READY(rdy),
      .REFRESH_LOST(lost), .RESUME(resume), .CKE(cke), .CS_N(cs_n),
      .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .A(a),
      .DQM(dqm), .DQ_O(dq), .DQ_OE(oe), .INIT_DONE(done),
      .REQ_READY_R(rdy_r));
   sdram_dev_model u_mem (.clk(clk), .cke(cke), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .a(a),
      .dqm(dqm), .dq(dq));
   //////////////////////////////////////////////
   task automatic print_verdict;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // inputs move one ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // valid stays up so pushes can run back to back
   task automatic push(input logic [2:0] op, input logic ap,
      input logic [ADDR_W-1:0] ad, input logic [31:0] d, m);
      int n;
      rq = '{op, ap, 2'h0, ad, d, m[3:0]};
      vld = 1'b1;
      for (n = 0; n < 200 && rdy !== 1'b1; n++) tick(1);
      if (n == 200) errors++; // the queue never took the request
      tick(1);
   endtask
   task automatic settle;
      vld = 1'b0;
      tick(12);
   endtask
   task automatic t_init;
      for (int n = 0; n < 200 && done !== 1'b1; n++) tick(1);
      chk("init_done", 1, done);
      chk("init_refs", 2, u_mem.n_cmd[CMD_REFRESH]);
   endtask
   task automatic t_writes;
      push(OP_WRITE, 0, 13'h1, 32'h11223344, 4'h0);
      push(OP_WRITE, 0, 13'h2, 32'h55667788, 4'h5);
      push(OP_WRITE, 0, 13'h3, 32'h99AABBCC, 4'hF);
      settle();
      chk("mem1", 32'h11223344, u_mem.mem[1]);
      chk("mem2", 32'h55007700, u_mem.mem[2]);
      chk("mem3", 32'h0, u_mem.mem[3]);
      chk("wr_gap", 1, u_mem.t_now - u_mem.t_prev);
   endtask
   // two commands pushed back to back, spacing measured at the pins
   task automatic gap(input logic [2:0] oa, input logic ap,
      input logic [2:0] ob, input logic [3:0] ca, cb, input int e);
      push(oa, ap, 13'h0, 32'h0, 4'h0);
      push(ob, 0, 13'h0, 32'h0, 4'h0);
      settle();
      chk("cmd_a", ca, u_mem.c_prev);
      chk("cmd_b", cb, u_mem.c_now);
      chk("gap", e, u_mem.t_now - u_mem.t_prev);
   endtask
   task automatic t_spacing;
      gap(OP_READ, 0, OP_READ, CMD_READ, CMD_READ, 1);
      gap(OP_READ, 0, OP_PRECHARGE, CMD_READ, CMD_PRECHARGE, 1);
      chk("float", 0, u_mem.lanes_on);
      gap(OP_WRITE, 0, OP_READ, CMD_WRITE, CMD_READ, 1);
      gap(OP_WRITE, 0, OP_BURST_STOP, CMD_WRITE, CMD_BURST_STOP, 1);
      gap(OP_WRITE, 0, OP_PRECHARGE, CMD_WRITE, CMD_PRECHARGE, 3);
      gap(OP_WRITE, 1, OP_ACTIVE, CMD_WRITE, CMD_ACTIVE, 6);
      gap(OP_MODE_LOAD, 0, OP_REFRESH, CMD_MODE_LOAD, CMD_REFRESH, 3);
   endtask
   // suspend, fill the queue until it refuses, then resume and drain
   task automatic t_fill;
      int n, w0;
      w0 = u_mem.n_cmd[CMD_WRITE];
      push(OP_SUSPEND, 0, 13'h0, 32'h0, 4'h0);
      vld = 1'b0;
      tick(4);
      chk("cke_low", 0, cke);
      for (n = 0; n < 20 && rdy === 1'b1; n++) begin
         rq = '{OP_WRITE, 1'b0, 2'(n), 13'(8 + n), 32'hA5A50000 + n, 4'h0};
         vld = 1'b1;
         tick(1);
      end
      vld = 1'b0;
      chk("fill", FIFO_DEPTH, n);
      tick(1);
      chk("ready_r", 0, rdy_r);
      chk("susp_wr", w0, u_mem.n_cmd[CMD_WRITE]);
      resume = 1'b1;
      tick(1);
      resume = 1'b0;
      tick(20);
      chk("drain", w0 + 8, u_mem.n_cmd[CMD_WRITE]);
      chk("mem15", 32'hA5A50007, u_mem.mem[15]);
      chk("bank", 2'h3, u_mem.b_now);
   endtask
   task automatic t_lost;
      int r0;
      r0 = u_mem.n_cmd[CMD_REFRESH];
      lost = 1'b1;
      tick(1);
      lost = 1'b0;
      tick(60);
      chk("rewake", r0 + 2, u_mem.n_cmd[CMD_REFRESH]);
      chk("redone", 1, done);
   endtask
   //////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // whole run is a few hundred cycles; this cuts a hang short
   initial begin
      #50000;
      errors++;
      print_verdict();
   end
   initial begin
      rst_b = 1'b0;
      vld = 1'b0;
      lost = 1'b0;
      resume = 1'b0;
      rq = '0;
      errors = 0;
      checked = 0;
      tick(16);
      rst_b = 1'b1;
      t_init();
      t_writes();
      t_spacing();
      t_fill();
      t_lost();
      print_verdict();
   end
endmodule
